// >>> bench/rcv_chk.sv
// Purpose: checker for verdicts and line framing of rcv_validity
// Assumes: design built with default parameters
// Notes:   bound by name to every instance
module rcv_chk (
	input wire logic                mclk,
	input wire logic                rst,
	input wire logic [7:0]          rx_byte,
	input wire logic                rx_valid,
	input wire logic                setup_write_mode,
	input wire logic                line_done,
	input wire logic                req_valid,
	input wire rcv_pkg::rcv_req_t   req,
	input wire rcv_pkg::rcv_state_t rec_state,
	input wire logic                info_command_b_mounted,
	input wire logic                resp_valid,
	input wire rcv_pkg::rcv_resp_t  resp
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_resp_one_kind: assert property (resp_valid |-> $onehot({resp.accepted,
		resp.unsupported, resp.wrong_state})) else $error("verdict not one-hot");
	a_resp_follows: assert property (req_valid |=> resp_valid
		&& resp.cmd == $past(req.cmd)) else $error("verdict late or wrong");
	a_mask_change: assert property (req_valid && req.cmd ==
		rcv_pkg::RCV_CMD_MASK && !req.query && rec_state == rcv_pkg::RCV_ST_PLAYBACK_COMMAND
		|=> resp.wrong_state) else $error("mask change taken in playback_command");
	a_load_twice: assert property (req_valid && req.cmd ==
		rcv_pkg::RCV_CMD_LOAD && info_command_b_mounted |=> !resp.accepted)
		else $error("load taken while loaded");
	a_event_record: assert property (req_valid && req.cmd ==
		rcv_pkg::RCV_CMD_EVENT && rec_state == rcv_pkg::RCV_ST_RECORD
		|=> resp.accepted) else $error("event refused in record");
	a_rec_in_playback_command: assert property (req_valid && req.cmd ==
		rcv_pkg::RCV_CMD_RECORD && rec_state == rcv_pkg::RCV_ST_PLAYBACK_COMMAND
		|=> !resp.accepted) else $error("record taken in playback_command");
	a_status_any: assert property (req_valid && req.cmd ==
		rcv_pkg::RCV_CMD_STATUS && rec_state != rcv_pkg::RCV_ST_POWER_ON
		|=> resp.accepted) else $error("status refused");
	a_line_end: assert property (rx_valid && rx_byte == 8'h0A &&
		$past(rx_valid && rx_byte == 8'h0D) && !setup_write_mode |=> line_done)
		else $error("line end missed");
	c_line: cover property (line_done);
	c_wrong: cover property (resp_valid && resp.wrong_state);
	c_unsup: cover property (resp_valid && resp.unsupported);
endmodule

bind rcv_validity rcv_chk chk(.*);

// >>> bench/rcv_host.sv
// Purpose: host side model that sends characters and decoded commands
// Assumes: bench calls its tasks at falling edges
// Notes:   released lines show inverted values
module rcv_host (
	input wire logic          mclk,
	output logic [7:0]        rx_byte,
	output logic              rx_valid,
	output logic              req_valid,
	output rcv_pkg::rcv_req_t req
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		rx_valid = 1'b0;
		rx_byte = 8'h00;
		req_valid = 1'b0;
		req = '0;
	end
	task put(input logic [7:0] b);
		@(negedge mclk);
		rx_valid = 1'b1;
		rx_byte = b;
	endtask
	task idle;
		@(negedge mclk);
		rx_valid = 1'b0;
		rx_byte = ~rx_byte;
	endtask
	task cmd(input rcv_pkg::rcv_cmd_t c, input logic q);
		@(negedge mclk);
		req_valid = 1'b1;
		req = '{c, q, (c == rcv_pkg::RCV_CMD_SETUP_FILE) && !q};
		@(negedge mclk);
		req_valid = 1'b0;
		req = rcv_pkg::rcv_req_t'(~req);
	endtask
endmodule

// >>> bench/recorder_command_validity_bench.sv
// Purpose: self-checking bench for rcv_validity
// Assumes: inputs change at falling edges
// Notes:   verdict code is valid, accepted, unsupported, wrong state
module recorder_command_validity_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic                     mclk, rst, setup_write_mode, info_command_b_mounted;
	logic [7:0]               rx_byte;
	logic                     rx_valid, req_valid, line_done, resp_valid;
	rcv_pkg::rcv_state_t      s;
	rcv_pkg::rcv_info_command_b_type_t info_command_b_type;
	rcv_pkg::rcv_req_t        req;
	rcv_pkg::rcv_resp_t       resp;
	int                       bad_count = 0;
	int                       n_checks = 0;
	rcv_validity dut(.mclk(mclk), .rst(rst), .rx_byte(rx_byte),
		.rx_valid(rx_valid), .setup_write_mode(setup_write_mode),
		.line_done(line_done), .req_valid(req_valid), .req(req),
		.rec_state(s), .info_command_b_mounted(info_command_b_mounted),
		.info_command_b_type(info_command_b_type), .resp_valid(resp_valid), .resp(resp));
	rcv_host host(.mclk(mclk), .rx_byte(rx_byte), .rx_valid(rx_valid),
		.req_valid(req_valid), .req(req));
	task cmp(input logic [3:0] got, input logic [3:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t got %b want %b", $time, got, exp);
		end
	endtask
	task ask(input rcv_pkg::rcv_cmd_t c, input logic q, input logic [2:0] e);
		host.cmd(c, q);
		cmp({resp_valid, resp.accepted, resp.unsupported, resp.wrong_state},
			{1'b1, e});
	endtask
	task t_rules;
		s = rcv_pkg::RCV_ST_IDLE;
		ask(rcv_pkg::RCV_CMD_MASK, 1'b0, 3'h4);
		ask(rcv_pkg::RCV_CMD_EVENT, 1'b0, 3'h1);
		ask(rcv_pkg::RCV_CMD_STOP, 1'b0, 3'h1);
		ask(rcv_pkg::RCV_CMD_SANITIZE, 1'b0, 3'h4);
		ask(rcv_pkg::RCV_CMD_UNKNOWN, 1'b0, 3'h2);
		info_command_b_mounted = 1'b1;
		ask(rcv_pkg::RCV_CMD_LOAD, 1'b0, 3'h1);
		ask(rcv_pkg::RCV_CMD_UNLOAD, 1'b0, 3'h4);
		info_command_b_mounted = 1'b0;
		ask(rcv_pkg::RCV_CMD_UNLOAD, 1'b0, 3'h1);
		s = rcv_pkg::RCV_ST_PLAYBACK_COMMAND;
		ask(rcv_pkg::RCV_CMD_MASK, 1'b0, 3'h1);
		ask(rcv_pkg::RCV_CMD_TIME, 1'b1, 3'h4);
		ask(rcv_pkg::RCV_CMD_RECORD, 1'b0, 3'h1);
		s = rcv_pkg::RCV_ST_RECORD;
		ask(rcv_pkg::RCV_CMD_EVENT, 1'b0, 3'h4);
		ask(rcv_pkg::RCV_CMD_PLAYBACK, 1'b0, 3'h1);
		s = rcv_pkg::RCV_ST_BUSY;
		ask(rcv_pkg::RCV_CMD_STATUS, 1'b0, 3'h4);
		$display("t_rules done");
	endtask
	task t_frame;
		host.put(8'h0D);
		host.put(8'h0A);
		host.idle;
		cmp({3'h0, line_done}, 4'h1);
		setup_write_mode = 1'b1;
		host.put(8'h0D);
		host.put(8'h0A);
		host.idle;
		cmp({3'h0, line_done}, 4'h0);
		host.put(8'h45);
		host.put(8'h4E);
		host.put(8'h44);
		host.put(8'h0D);
		host.put(8'h0A);
		host.idle;
		cmp({3'h0, line_done}, 4'h1);
		setup_write_mode = 1'b0;
		$display("t_frame done");
	endtask
	task t_grid;
		s = rcv_pkg::RCV_ST_ERROR;
		ask(rcv_pkg::RCV_CMD_BIT, 1'b0, 3'h4);
		ask(rcv_pkg::RCV_CMD_SETUP, 1'b0, 3'h4);
		info_command_b_type = rcv_pkg::RCV_TYPE_TAPE;
		ask(rcv_pkg::RCV_CMD_ERASE, 1'b0, 3'h4);
		ask(rcv_pkg::RCV_CMD_SETUP_FILE, 1'b0, 3'h4);
		info_command_b_type = rcv_pkg::RCV_TYPE_DISK;
		s = rcv_pkg::RCV_ST_FAIL;
		ask(rcv_pkg::RCV_CMD_BIT, 1'b0, 3'h4);
		ask(rcv_pkg::RCV_CMD_EVENT, 1'b1, 3'h4);
		ask(rcv_pkg::RCV_CMD_DUB, 1'b0, 3'h1);
		ask(rcv_pkg::RCV_CMD_SETUP_FILE, 1'b0, 3'h1);
		s = rcv_pkg::RCV_ST_FIND;
		ask(rcv_pkg::RCV_CMD_STOP, 1'b0, 3'h4);
		ask(rcv_pkg::RCV_CMD_RECORD, 1'b0, 3'h1);
		ask(rcv_pkg::RCV_CMD_FIND, 1'b0, 3'h1);
		s = rcv_pkg::RCV_ST_SANITIZE;
		ask(rcv_pkg::RCV_CMD_HELP, 1'b0, 3'h4);
		ask(rcv_pkg::RCV_CMD_INFO, 1'b0, 3'h1);
		s = rcv_pkg::RCV_ST_ERASE;
		ask(rcv_pkg::RCV_CMD_HEALTH, 1'b0, 3'h4);
		ask(rcv_pkg::RCV_CMD_FILES, 1'b0, 3'h1);
		s = rcv_pkg::RCV_ST_POWER_ON;
		ask(rcv_pkg::RCV_CMD_RESET, 1'b0, 3'h1);
		s = rcv_pkg::RCV_ST_BIT;
		ask(rcv_pkg::RCV_CMD_TIME, 1'b1, 3'h4);
		ask(rcv_pkg::RCV_CMD_SETUP, 1'b0, 3'h1);
		s = rcv_pkg::RCV_ST_REC_PLAYBACK_COMMAND;
		ask(rcv_pkg::RCV_CMD_EVENT, 1'b0, 3'h4);
		ask(rcv_pkg::RCV_CMD_REPLAY, 1'b0, 3'h1);
		s = rcv_pkg::RCV_ST_RECORD;
		ask(rcv_pkg::RCV_CMD_LOOP, 1'b0, 3'h4);
		ask(rcv_pkg::RCV_CMD_SHUTTLE, 1'b0, 3'h4);
		$display("t_grid done");
	endtask
	task t_reset;
		host.put(8'h0D);
		host.idle;
		rst = 1'b1;
		repeat (2) @(negedge mclk);
		cmp({resp_valid, resp.accepted, resp.unsupported,
			resp.wrong_state}, 4'h0);
		rst = 1'b0;
		host.put(8'h0A);
		host.idle;
		cmp({3'h0, line_done}, 4'h0);
		$display("t_reset done");
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		#40000;
		bad_count++;
		wrap_up;
	end
	initial begin
		rst = 1'b1;
		setup_write_mode = 1'b0;
		info_command_b_mounted = 1'b0;
		s = rcv_pkg::RCV_ST_IDLE;
		info_command_b_type = rcv_pkg::RCV_TYPE_SOLID;
		repeat (8) @(posedge mclk);
		@(negedge mclk);
		rst = 1'b0;
		t_rules;
		t_grid;
		t_frame;
		t_reset;
		wrap_up;
	end
endmodule

// >>> design/rcv_pkg.sv
// Purpose: shared types and constants for the recorder command validity block
// Assumes: commands arrive already decoded by an upstream text parser
// Notes:   one command code per command word, states of the recorder
package rcv_pkg;

	typedef enum logic [4:0] {
		RCV_CMD_BIT,
		RCV_CMD_MASK,
		RCV_CMD_SANITIZE,
		RCV_CMD_UNLOAD,
		RCV_CMD_DUB,
		RCV_CMD_ERASE,
		RCV_CMD_EVENT,
		RCV_CMD_FILES,
		RCV_CMD_FIND,
		RCV_CMD_HEALTH,
		RCV_CMD_HELP,
		RCV_CMD_LOOP,
		RCV_CMD_INFO,
		RCV_CMD_LOAD,
		RCV_CMD_PLAYBACK,
		RCV_CMD_RECORD,
		RCV_CMD_REPLAY,
		RCV_CMD_RESET,
		RCV_CMD_SETUP,
		RCV_CMD_SHUTTLE,
		RCV_CMD_STATUS,
		RCV_CMD_STOP,
		RCV_CMD_TIME,
		RCV_CMD_SETUP_FILE,
		RCV_CMD_UNKNOWN
	} rcv_cmd_t;

	typedef enum logic [3:0] {
		RCV_ST_BIT,
		RCV_ST_BUSY,
		RCV_ST_SANITIZE,
		RCV_ST_ERASE,
		RCV_ST_ERROR,
		RCV_ST_FAIL,
		RCV_ST_FIND,
		RCV_ST_IDLE,
		RCV_ST_PLAYBACK_COMMAND,
		RCV_ST_POWER_ON,
		RCV_ST_RECORD,
		RCV_ST_REC_PLAYBACK_COMMAND
	} rcv_state_t;

	typedef enum logic [1:0] {
		RCV_TYPE_TAPE,
		RCV_TYPE_SOLID,
		RCV_TYPE_DISK
	} rcv_info_command_b_type_t;

	// Decoded command as handed over by the parser
	typedef struct packed {
		rcv_cmd_t cmd;
		logic     query;
		logic     setup_write;
	} rcv_req_t;

	// Verdict handed back for the response text
	typedef struct packed {
		logic     accepted;
		logic     unsupported;
		logic     wrong_state;
		rcv_cmd_t cmd;
	} rcv_resp_t;

	localparam logic [7:0] RCV_CHAR_CR = 8'h0D;
	localparam logic [7:0] RCV_CHAR_LF = 8'h0A;
	localparam logic [7:0] RCV_CHAR_E  = 8'h45;
	localparam logic [7:0] RCV_CHAR_N  = 8'h4E;
	localparam logic [7:0] RCV_CHAR_D  = 8'h44;

	localparam logic [2:0] RCV_TERM_RST = 3'h0;

endpackage

// >>> design/rcv_validity.sv
// Purpose: frame command lines and judge each command against recorder state
// Assumes: bytes and decoded commands come from logic on mclk
// Notes:   rejected commands never change state; resp_valid is a one-cycle pulse, verdict holds until the next request
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Mask/setup/time changes only idle or error
// - Load only unloaded, unload only loaded
// - Event query in all states but busy, power-on, sanitize and erase; declaring while recording
// - Record with playback is an option
// - Mandatory command set depends on recorder type
// - Line ends at CR LF, setup-file at END
module rcv_validity #(
	parameter bit OPT_EVENT_IDLE  = 1'b0,
	parameter bit OPT_REC_PLAYBACK_COMMAND    = 1'b0,
	parameter bit OPT_OPTIONAL_ON = 1'b1
) (
	input  wire logic                     mclk,
	input  wire logic                     rst,
	input  wire logic [7:0]               rx_byte,
	input  wire logic                     rx_valid,
	input  wire logic                     setup_write_mode,
	output logic                          line_done,
	input  wire logic                     req_valid,
	input  wire rcv_pkg::rcv_req_t        req,
	input  wire rcv_pkg::rcv_state_t      rec_state,
	input  wire logic                     info_command_b_mounted,
	input  wire rcv_pkg::rcv_info_command_b_type_t info_command_b_type,
	output logic                          resp_valid,
	output rcv_pkg::rcv_resp_t            resp
);

	////////////////////////////////////////////////////////////////////////
	// Line framing
	typedef enum logic [2:0] {
		RCV_TS_HUNT,
		RCV_TS_LINE,
		RCV_TS_E,
		RCV_TS_N,
		RCV_TS_D,
		RCV_TS_CR
	} rcv_term_t;

	rcv_term_t term_seq;
	logic      prev_cr;
	logic      byte_cr;
	logic      byte_lf;
	logic      byte_e;
	logic      byte_n;
	logic      byte_d;
	logic      crlf_now;
	logic      end_now;

	// Character classes of the byte now on rx_byte
	always_comb begin
		byte_cr  = (rx_byte == rcv_pkg::RCV_CHAR_CR);
		byte_lf  = (rx_byte == rcv_pkg::RCV_CHAR_LF);
		byte_e   = (rx_byte == rcv_pkg::RCV_CHAR_E);
		byte_n   = (rx_byte == rcv_pkg::RCV_CHAR_N);
		byte_d   = (rx_byte == rcv_pkg::RCV_CHAR_D);
		crlf_now = rx_valid && prev_cr && byte_lf;
		end_now  = rx_valid && byte_lf && (term_seq == RCV_TS_CR);
	end

	// Whether the last valid byte was a CR
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			prev_cr <= 1'b0;
		end else if (rx_valid) begin
			prev_cr <= byte_cr;
		end
	end

	// Tracks CR LF E N D CR LF for the setup-file upload
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			term_seq <= rcv_term_t'(rcv_pkg::RCV_TERM_RST);
		end else if (rx_valid) begin
			if (!setup_write_mode) begin
				term_seq <= RCV_TS_HUNT;
			end else begin
				case (term_seq)
				RCV_TS_HUNT:
					term_seq <= crlf_now ? RCV_TS_LINE : RCV_TS_HUNT;
				RCV_TS_LINE:
					term_seq <= byte_e ? RCV_TS_E : RCV_TS_HUNT;
				RCV_TS_E:
					term_seq <= byte_n ? RCV_TS_N : RCV_TS_HUNT;
				RCV_TS_N:
					term_seq <= byte_d ? RCV_TS_D : RCV_TS_HUNT;
				RCV_TS_D:
					term_seq <= byte_cr ? RCV_TS_CR : RCV_TS_HUNT;
				RCV_TS_CR:
					// The closing CR LF also opens the next line
					term_seq <= byte_lf ? RCV_TS_LINE : RCV_TS_HUNT;
				default:
					term_seq <= RCV_TS_HUNT;
				endcase
			end
		end
	end

	// One-cycle pulse once the command line is complete
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			line_done <= 1'b0;
		end else begin
			line_done <= setup_write_mode ? end_now : crlf_now;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Support check
	logic supported;

	always_comb begin
		supported = OPT_OPTIONAL_ON;
		case (req.cmd)
		rcv_pkg::RCV_CMD_BIT, rcv_pkg::RCV_CMD_FIND, rcv_pkg::RCV_CMD_INFO,
		rcv_pkg::RCV_CMD_PLAYBACK, rcv_pkg::RCV_CMD_RECORD,
		rcv_pkg::RCV_CMD_RESET, rcv_pkg::RCV_CMD_STATUS,
		rcv_pkg::RCV_CMD_STOP:
			supported = 1'b1;
		rcv_pkg::RCV_CMD_SANITIZE, rcv_pkg::RCV_CMD_ERASE:
			supported = (info_command_b_type != rcv_pkg::RCV_TYPE_TAPE)
				|| OPT_OPTIONAL_ON;
		rcv_pkg::RCV_CMD_UNKNOWN:
			supported = 1'b0;
		default:
			supported = OPT_OPTIONAL_ON;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// State check
	logic valid_in_state;
	logic st_idle_err;
	logic st_recording;
	logic st_common;

	always_comb begin
		st_idle_err  = (rec_state == rcv_pkg::RCV_ST_IDLE)
			|| (rec_state == rcv_pkg::RCV_ST_ERROR);
		st_recording = (rec_state == rcv_pkg::RCV_ST_RECORD)
			|| (rec_state == rcv_pkg::RCV_ST_REC_PLAYBACK_COMMAND);
		// All states but busy and power-on
		st_common = (rec_state != rcv_pkg::RCV_ST_BUSY)
			&& (rec_state != rcv_pkg::RCV_ST_POWER_ON);
		valid_in_state = 1'b0;
		case (req.cmd)
		rcv_pkg::RCV_CMD_MASK, rcv_pkg::RCV_CMD_SETUP, rcv_pkg::RCV_CMD_TIME:
			valid_in_state = req.query ? st_common : st_idle_err;
		rcv_pkg::RCV_CMD_LOAD:
			valid_in_state = st_idle_err && !info_command_b_mounted;
		rcv_pkg::RCV_CMD_UNLOAD:
			valid_in_state = st_idle_err && info_command_b_mounted;
		rcv_pkg::RCV_CMD_EVENT:
			valid_in_state = st_common && (rec_state != rcv_pkg::RCV_ST_SANITIZE)
				&& (rec_state != rcv_pkg::RCV_ST_ERASE)
				&& (req.query || st_recording || OPT_EVENT_IDLE);
		rcv_pkg::RCV_CMD_PLAYBACK:
			valid_in_state = st_idle_err
				|| (rec_state == rcv_pkg::RCV_ST_RECORD && OPT_REC_PLAYBACK_COMMAND);
		rcv_pkg::RCV_CMD_RECORD:
			valid_in_state = st_idle_err
				|| ((rec_state == rcv_pkg::RCV_ST_FIND
				|| rec_state == rcv_pkg::RCV_ST_PLAYBACK_COMMAND) && OPT_REC_PLAYBACK_COMMAND);
		rcv_pkg::RCV_CMD_BIT:
			valid_in_state = st_idle_err || rec_state == rcv_pkg::RCV_ST_FAIL;
		rcv_pkg::RCV_CMD_SANITIZE, rcv_pkg::RCV_CMD_ERASE,
		rcv_pkg::RCV_CMD_SETUP_FILE:
			valid_in_state = st_idle_err;
		rcv_pkg::RCV_CMD_DUB, rcv_pkg::RCV_CMD_FIND, rcv_pkg::RCV_CMD_LOOP,
		rcv_pkg::RCV_CMD_REPLAY, rcv_pkg::RCV_CMD_SHUTTLE:
			valid_in_state = st_idle_err
				|| rec_state == rcv_pkg::RCV_ST_RECORD;
		rcv_pkg::RCV_CMD_FILES, rcv_pkg::RCV_CMD_INFO:
			valid_in_state = st_common && (rec_state != rcv_pkg::RCV_ST_SANITIZE)
				&& (rec_state != rcv_pkg::RCV_ST_ERASE);
		rcv_pkg::RCV_CMD_HEALTH, rcv_pkg::RCV_CMD_HELP:
			valid_in_state = st_common;
		rcv_pkg::RCV_CMD_RESET, rcv_pkg::RCV_CMD_STATUS:
			valid_in_state = rec_state != rcv_pkg::RCV_ST_POWER_ON;
		rcv_pkg::RCV_CMD_STOP:
			valid_in_state = rec_state == rcv_pkg::RCV_ST_FIND
				|| rec_state == rcv_pkg::RCV_ST_PLAYBACK_COMMAND || st_recording;
		default:
			valid_in_state = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Verdict register
	rcv_pkg::rcv_resp_t next_resp;

	// Exactly one verdict bit is set for every request
	always_comb begin
		next_resp             = '0;
		next_resp.cmd         = req.cmd;
		next_resp.unsupported = !supported;
		next_resp.wrong_state = supported && !valid_in_state;
		next_resp.accepted    = supported && valid_in_state;
	end

	// One-cycle pulse a cycle after each request
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			resp_valid <= 1'b0;
		end else begin
			resp_valid <= req_valid;
		end
	end

	// Verdict holds until the next request
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			resp <= '0;
		end else if (req_valid) begin
			resp <= next_resp;
		end
	end

endmodule
